// ===== smb_das.sv
/*
 * Byte FIFO and SMBus data, own-address and status registers.
 * Assumes the bus state machine supplies bit strobes, state codes and the
 * service flag, all synchronous to core_clk.
 */
`timescale 1ns/100ps

module smb_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} smb_fifo_st_t;

	smb_fifo_st_t st_r, st_nxt;
	logic         push;
	logic         pop;
	logic         full;
	logic         empty;

	// Full and empty come straight from the count, so they never lie
	assign full      = (st_r.cnt == (AW+1)'(D));
	assign empty     = (st_r.cnt == '0);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = st_r.mem[st_r.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wp] = in_data;
			st_nxt.wp = (st_r.wp == AW'(D-1)) ? '0 : st_r.wp + 1'b1;
		end
		if (pop) begin
			st_nxt.rp = (st_r.rp == AW'(D-1)) ? '0 : st_r.rp + 1'b1;
		end
		st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : smb_fifo

module smb_das (
	// Clock and reset
	input  wire logic                             core_clk,
	input  wire logic                             rst_n,
	// Special function register port
	input  wire logic [7:0]                       sfr_addr,
	input  wire logic                             sfr_wr,
	input  wire logic                             sfr_rd,
	input  wire logic [smb_pkg::SMB_BYTE_W-1:0]   sfr_wdata,
	output logic [smb_pkg::SMB_BYTE_W-1:0]        sfr_rdata,
	// From the bus state machine
	input  wire logic                             smb_enable,
	input  wire logic                             service_flag,
	input  wire logic                             master_mode,
	input  wire logic                             byte_start,
	input  wire logic                             address_byte,
	input  wire logic                             bit_strobe,
	input  wire logic                             bus_bit_in,
	input  wire logic [smb_pkg::SMB_CODE_W-1:0]   state_code,
	input  wire logic                             state_load,
	input  wire logic                             bus_error,
	input  wire logic                             bus_idle,
	// To the bus state machine
	output logic                                  bus_bit_out,
	output logic                                  byte_done,
	output logic                                  own_addr_match,
	output logic                                  general_call_match,
	output logic                                  stretch_req,
	// Received byte stream
	output logic [smb_pkg::SMB_BYTE_W-1:0]        rx_data,
	output logic                                  rx_valid,
	input  wire logic                             rx_ready
);
	import smb_pkg::*;

	typedef struct packed {
		smb_phase_t                phase;
		logic [SMB_BYTE_W-1:0]     serial_byte_register;
		logic [SMB_BYTE_W-1:0]     own_slave_address;
		logic [SMB_CODE_W-1:0]     state_code_bits;
		logic [3:0]                bit_cnt;
		logic                      done;
		logic                      own_hit;
		logic                      gc_hit;
		logic [SMB_BYTE_W-1:0]     rdata;
	} smb_das_st_t;

	smb_das_st_t st_r, st_nxt;
	logic        fifo_ready;
	logic        sfr_open;
	logic [6:0]  rx_addr;
	logic [6:0]  own_address_bits;
	logic        general_call_enable;
	logic        wr_own;
	logic        wr_data;
	logic [7:0]  status_rd;
	logic        arm_ok;
	logic        slave_addr_byte;
	logic        addr_is_gc;
	logic        own_cmp;
	logic        gc_cmp;
	logic        code_hold;
	logic [4:0]  code_nxt;

	// Software may write data only while the core is parked on a service request or the port is disabled
	assign sfr_open            = service_flag || !smb_enable;
	assign own_address_bits    = st_r.own_slave_address[SMB_BYTE_W-1:1];
	assign general_call_enable = st_r.own_slave_address[SMB_GC_BIT];
	assign rx_addr             = st_r.serial_byte_register[SMB_BYTE_W-1:1];

	// Register port decode; status writes have no path in, so they cannot corrupt it
	assign wr_own    = sfr_wr && (sfr_addr == SMB_ADDR_OWN);
	assign wr_data   = sfr_wr && (sfr_addr == SMB_ADDR_DATA) && sfr_open;
	assign status_rd = {st_r.state_code_bits, SMB_CODE_PAD};

	// A disabled port never arms, so software owns the data register then
	assign arm_ok = byte_start && !service_flag && smb_enable;

	// Address recognition; the general call address is never taken as our own
	assign slave_addr_byte = address_byte && !master_mode;
	assign addr_is_gc      = (rx_addr == SMB_GC_ADDR);
	assign own_cmp         = slave_addr_byte && !addr_is_gc && (rx_addr == own_address_bits);
	assign gc_cmp          = slave_addr_byte && addr_is_gc && general_call_enable;

	// Status source by priority; frozen while a service request is pending
	assign code_hold = service_flag;
	assign code_nxt  = bus_error  ? SMB_CODE_BERR :
		state_load ? state_code :
		bus_idle   ? SMB_CODE_IDLE :
		st_r.state_code_bits;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;

		// Register writes; status writes are dropped rather than corrupting it
		if (wr_own) begin
			st_nxt.own_slave_address = sfr_wdata;
		end
		if (wr_data) begin
			st_nxt.serial_byte_register = sfr_wdata;
		end

		// Status code update only while no service request is pending
		if (!code_hold) begin
			st_nxt.state_code_bits = code_nxt;
		end

		case (st_r.phase)
			SMB_PH_IDLE: begin
				if (arm_ok) begin
					st_nxt.bit_cnt = '0;
					st_nxt.phase   = SMB_PH_SHIFT;
				end
			end
			SMB_PH_SHIFT: begin
				if (service_flag) begin
					st_nxt.phase = SMB_PH_IDLE;
				end else if (!smb_enable) begin
					// Disabling mid-byte drops the partial byte
					st_nxt.phase = SMB_PH_IDLE;
				end else if (bit_strobe) begin
					// One register both ways: what leaves at the top is replaced by the wire
					st_nxt.serial_byte_register =
						{st_r.serial_byte_register[SMB_BYTE_W-2:0], bus_bit_in};
					st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
					if (st_r.bit_cnt + 4'h1 == SMB_BITS_BYTE) begin
						st_nxt.phase = SMB_PH_PUSH;
					end
				end
			end
			SMB_PH_PUSH: begin
				// Hold the clock low until the FIFO has room for the byte
				if (fifo_ready) begin
					st_nxt.done    = 1'b1;
					st_nxt.own_hit = own_cmp;
					st_nxt.gc_hit  = gc_cmp;
					st_nxt.phase   = SMB_PH_IDLE;
				end
			end
			default: begin
				st_nxt.phase = SMB_PH_IDLE;
			end
		endcase

		if (byte_start) begin
			st_nxt.own_hit = 1'b0;
			st_nxt.gc_hit  = 1'b0;
		end

		// Read data
		st_nxt.rdata = '0;
		if (sfr_rd) begin
			case (sfr_addr)
				SMB_ADDR_STATE: st_nxt.rdata = status_rd;
				SMB_ADDR_DATA:  st_nxt.rdata = st_r.serial_byte_register;
				SMB_ADDR_OWN:   st_nxt.rdata = st_r.own_slave_address;
				default:        st_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r.phase                <= SMB_PH_IDLE;
			st_r.serial_byte_register <= SMB_DATA_RST;
			st_r.own_slave_address    <= SMB_OWN_RST;
			st_r.state_code_bits      <= SMB_CODE_RST;
			st_r.bit_cnt              <= '0;
			st_r.done                 <= 1'b0;
			st_r.own_hit              <= 1'b0;
			st_r.gc_hit               <= 1'b0;
			st_r.rdata                <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	smb_fifo #(
		.W(SMB_BYTE_W),
		.D(SMB_FIFO_D)
	) u_rx_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (st_r.phase == SMB_PH_PUSH),
		.in_ready  (fifo_ready),
		.in_data   (st_r.serial_byte_register),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);

	assign bus_bit_out        = st_r.serial_byte_register[SMB_BYTE_W-1];
	assign byte_done          = st_r.done;
	assign own_addr_match     = st_r.own_hit;
	assign general_call_match = st_r.gc_hit;
	assign stretch_req        = (st_r.phase == SMB_PH_PUSH) && !fifo_ready;
	assign sfr_rdata          = st_r.rdata;
endmodule : smb_das

// ===== smb_pkg.sv
/*
 * Constants for the data, own-address and status part of a two-wire SMBus port.
 * Assumes an 8-bit special function register port and a 40 MHz core clock.
 */
// Functional notes
// - Data register accessible while service flag set
// - Shift out MSB first, first in lands MSB
// - Bus value shifted in while shifting out
// - Lost arbitration leaves correct received byte
// - Own address taken from bits 7 to 1
// - Top address bit matches first received bit
// - General call recognised only when bit 0 set
// - Own address ignored while bus master
// - State reported as one of 28 codes
// - Code in bits 7-3, bits 2-0 zero
// - Status valid only while service flag set
// - Idle shows 0xf8 without service flag
// - Illegal start or stop reports code 0x00
package smb_pkg;
	localparam logic [7:0] SMB_ADDR_STATE = 8'hc1;
	localparam logic [7:0] SMB_ADDR_DATA  = 8'hc2;
	localparam logic [7:0] SMB_ADDR_OWN   = 8'hc3;
	localparam int         SMB_BYTE_W     = 8;
	localparam int         SMB_FIFO_D     = 8;
	localparam int         SMB_CODE_W     = 5;
	localparam int         SMB_CODE_LSB   = 3;
	localparam logic [7:0] SMB_OWN_RST    = 8'h00;
	localparam logic [7:0] SMB_DATA_RST   = 8'h00;
	localparam logic [4:0] SMB_CODE_RST   = 5'h00;
	localparam logic [4:0] SMB_CODE_IDLE  = 5'h1f;
	localparam logic [4:0] SMB_CODE_BERR  = 5'h00;
	localparam logic [3:0] SMB_BITS_BYTE  = 4'h8;
	localparam int         SMB_GC_BIT     = 0;
	localparam logic [6:0] SMB_GC_ADDR    = 7'h00;
	localparam logic [2:0] SMB_CODE_PAD   = 3'h0;

	typedef enum logic [1:0] {
		SMB_PH_IDLE  = 2'b00,
		SMB_PH_SHIFT = 2'b01,
		SMB_PH_PUSH  = 2'b11
	} smb_phase_t;
endpackage : smb_pkg

// ===== smb_das_props.sv
/*
 * Port checker for the SMBus data, address and status block.
 * Assumes it is bound to every smb_das instance.
 */
`timescale 1ns/100ps

module smb_das_props (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst_n,
	// Register port
	input wire logic       sfr_rd,
	input wire logic       service_flag,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_rdata,
	// Shifter side
	input wire logic       master_mode,
	input wire logic       byte_start,
	input wire logic       byte_done,
	input wire logic       rx_valid,
	input wire logic       own_addr_match,
	input wire logic       general_call_match
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Status read while the flag is set
	sequence rd_st;
		sfr_rd && sfr_addr == 8'hc1 && service_flag;
	endsequence
	chk_status_pad: assert property (rd_st |=> sfr_rdata[2:0] == 3'h0)
		else $error("status low bits not zero");
	chk_status_hold: assert property (rd_st ##1 service_flag ##1 rd_st |=> sfr_rdata == $past(sfr_rdata, 2))
		else $error("status moved under flag");
	chk_rd_idle: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
		else $error("read data without read");
	chk_done_pulse: assert property (byte_done |=> !byte_done)
		else $error("byte done too long");
	chk_done_valid: assert property (byte_done |-> rx_valid)
		else $error("byte done with empty fifo");
	chk_match_clear: assert property (byte_start |=> !own_addr_match && !general_call_match)
		else $error("match not cleared");
	chk_match_hold: assert property (own_addr_match && !byte_start |=> own_addr_match)
		else $error("match dropped early");
	chk_master_ign: assert property (byte_done && master_mode && $past(master_mode) |-> !own_addr_match)
		else $error("address match as master");
endmodule : smb_das_props

bind smb_das smb_das_props u_props (
	.core_clk (core_clk), .rst_n (rst_n), .sfr_rd (sfr_rd), .service_flag (service_flag),
	.sfr_addr (sfr_addr), .sfr_rdata (sfr_rdata), .master_mode (master_mode), .byte_start (byte_start),
	.byte_done (byte_done), .rx_valid (rx_valid), .own_addr_match (own_addr_match),
	.general_call_match (general_call_match)
);

// ===== smb_peer.sv
/*
 * Remote bus party: clocks one byte into the shifter, records what it saw.
 * Assumes the bench arms the shifter before calling send.
 */
`timescale 1ns/100ps

module smb_peer (
	// Clock
	input  wire logic  core_clk,
	// Bit lane
	input  wire logic  bus_bit_out,
	output logic       bit_strobe,
	output logic       bus_bit_in,
	output logic [7:0] seen
);
	// Released line floats high on its pull-up
	initial begin
		bit_strobe = 1'b0;
		bus_bit_in = 1'b1;
		seen       = 8'h00;
	end

	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge core_clk) #2;
			bus_bit_in = b[i];
			seen       = {seen[6:0], bus_bit_out};
			bit_strobe = 1'b1;
			@(posedge core_clk) #2;
			bit_strobe = 1'b0;
			bus_bit_in = 1'b1;
		end
	endtask : send
endmodule : smb_peer

// ===== tb.sv
/*
 * Self-checking bench for smb_das with a remote bus party model.
 * Assumes smb_peer and the bound checker are compiled alongside.
 */
`timescale 1ns/100ps

module tb;
	logic       core_clk, rst_n, sfr_wr, sfr_rd, smb_enable, service_flag, master_mode, byte_start;
	logic       address_byte, state_load, bus_error, bus_idle, rx_ready, bit_strobe, bus_bit_in;
	logic       bus_bit_out, byte_done, own_addr_match, general_call_match, stretch_req, rx_valid;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rx_data, seen;
	logic [4:0] state_code;
	int         num_errors, n_tests;

	smb_das uut (
		.core_clk (core_clk), .rst_n (rst_n), .sfr_addr (sfr_addr), .sfr_wr (sfr_wr), .sfr_rd (sfr_rd),
		.sfr_wdata (sfr_wdata), .sfr_rdata (sfr_rdata), .smb_enable (smb_enable), .service_flag (service_flag),
		.master_mode (master_mode), .byte_start (byte_start), .address_byte (address_byte),
		.bit_strobe (bit_strobe), .bus_bit_in (bus_bit_in), .state_code (state_code), .state_load (state_load),
		.bus_error (bus_error), .bus_idle (bus_idle), .bus_bit_out (bus_bit_out), .byte_done (byte_done),
		.own_addr_match (own_addr_match), .general_call_match (general_call_match),
		.stretch_req (stretch_req), .rx_data (rx_data), .rx_valid (rx_valid), .rx_ready (rx_ready)
	);
	smb_peer peer (.core_clk, .bus_bit_out, .bit_strobe, .bus_bit_in, .seen);

	always #12.5 core_clk = ~core_clk;

	task summarize;
		$display("tests=%0d errors=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) #2;
		{sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
		@(posedge core_clk) #2;
		sfr_wr = 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk) #2;
		{sfr_addr, sfr_rd} = {a, 1'b1};
		@(posedge core_clk) #2;
		sfr_rd = 1'b0;
		chk(sfr_rdata, e);
	endtask : rd

	task wait_done;
		int k;
		for (k = 0; k < 40 && byte_done !== 1'b1; k++) @(posedge core_clk) #2;
		if (byte_done !== 1'b1) begin
			num_errors++;
			summarize;
		end
	endtask : wait_done

	task bin(input logic [7:0] b);
		@(posedge core_clk) #2 byte_start = 1'b1;
		@(posedge core_clk) #2 byte_start = 1'b0;
		peer.send(b);
	endtask : bin

	task sb(input logic [7:0] b, input logic mm, input logic own, input logic gc);
		master_mode = mm;
		bin(b);
		wait_done;
		chk(rx_data, b);
		chk({6'h0, own_addr_match, general_call_match}, {6'h0, own, gc});
	endtask : sb

	initial begin
		{core_clk, rst_n, sfr_wr, sfr_rd, service_flag, master_mode, byte_start} = '0;
		{address_byte, state_load, bus_error, bus_idle, rx_ready, state_code} = '0;
		{sfr_addr, sfr_wdata, smb_enable} = {16'h0, 1'b1};
		repeat (16) @(posedge core_clk);
		#2 rst_n = 1'b1;
		rd(8'hc1, 8'h00);
		rd(8'hc0, 8'h00);
		wr(8'hc3, 8'ha5);
		rd(8'hc3, 8'ha5);
		$display("registers done");
		for (int i = 0; i < 29; i++) begin
			@(posedge core_clk) #2;
			{service_flag, state_code, state_load, bus_idle, bus_error} = {1'b0, i[4:0], i != 27, i == 27, i == 28};
			@(posedge core_clk) #2;
			{state_load, bus_idle, bus_error, service_flag} = 4'h1;
			rd(8'hc1, i == 27 ? 8'hf8 : i == 28 ? 8'h00 : {i[4:0], 3'h0});
		end
		// Status must hold while the flag is up; software never writes it
		{state_code, state_load} = {5'h05, 1'b1};
		@(posedge core_clk) #2 state_load = 1'b0;
		rd(8'hc1, 8'h00);
		rd(8'hc1, 8'h00);
		$display("status done");
		{service_flag, rx_ready, address_byte} = 3'b011;
		sb(8'ha4, 1'b0, 1'b1, 1'b0);
		sb(8'h24, 1'b0, 1'b0, 1'b0);
		sb(8'h00, 1'b0, 1'b0, 1'b1);
		sb(8'ha4, 1'b1, 1'b0, 1'b0);
		wr(8'hc3, 8'ha4);
		sb(8'h00, 1'b0, 1'b0, 1'b0);
		wr(8'hc3, 8'h00);
		sb(8'h00, 1'b0, 1'b0, 1'b0);
		$display("address done");
		service_flag = 1'b1;
		rd(8'hc2, 8'h00);
		wr(8'hc2, 8'h96);
		@(posedge core_clk) #2 chk({7'h0, bus_bit_out}, 8'h01);
		{service_flag, address_byte} = 2'b00;
		bin(8'h5a);
		wait_done;
		chk(seen, 8'h96);
		service_flag = 1'b1;
		rd(8'hc2, 8'h5a);
		{service_flag, smb_enable} = 2'b00;
		wr(8'hc2, 8'h3c);
		rd(8'hc2, 8'h3c);
		smb_enable = 1'b1;
		$display("shift done");
		// Fill past depth so the ninth byte stalls the bus
		{service_flag, rx_ready} = 2'b00;
		for (int i = 0; i < 9; i++) begin
			bin(i[7:0]);
			if (i < 8) wait_done;
		end
		repeat (4) @(posedge core_clk) #2;
		chk({7'h0, stretch_req}, 8'h01);
		for (int i = 0; i < 9; i++) begin
			chk(rx_data, i[7:0]);
			@(posedge core_clk) #2 rx_ready = 1'b1;
			@(posedge core_clk) #2 rx_ready = 1'b0;
			repeat (3) @(posedge core_clk) #2;
		end
		chk({7'h0, rx_valid}, 8'h00);
		$display("fifo done");
		summarize;
	end
endmodule : tb
